/* iebk_consts.svh */
`ifndef IEBK_CONSTS_SVH
`define IEBK_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IEBK_OFS_EN1 8'h00
`define IEBK_OFS_EN2 8'h04
`define IEBK_OFS_EN3 8'h08
`define IEBK_OFS_FLG1 8'h10
`define IEBK_OFS_FLG2 8'h14
`define IEBK_OFS_FLG3 8'h18
`define IEBK_OFS_PRI_FIRST 8'h20
`define IEBK_OFS_PRI_LAST 8'h4C

// ----------------------------------------------------------------
// implemented bit masks, one per bank word
// ----------------------------------------------------------------
`define IEBK_MASK1 16'hFEDF
`define IEBK_MASK2 16'h3FE3
`define IEBK_MASK3 16'h4066

// ----------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------
`define IEBK_EN_RST 16'h0000
`define IEBK_FLG_RST 16'h0000
`define IEBK_PRI_RST 3'h4
`define IEBK_PRI_OFF 3'h0
`define IEBK_PRI_FIELD_W 4
`define IEBK_PRI_PER_WORD 4
`define IEBK_NUM_POS 48

`endif

/* iebk_pkg.sv */
package iebk_pkg;

   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } iebk_apb_req_type;

   // one bit per source position, three 16-bit bank words
   typedef struct packed {
      logic [15:0] w3;
      logic [15:0] w2;
      logic [15:0] w1;
   } iebk_bank_type;

   // register group hit by an address
   typedef enum logic [1:0] {
      IEBK_KIND_NONE = 2'b00,
      IEBK_KIND_EN = 2'b01,
      IEBK_KIND_FLG = 2'b10,
      IEBK_KIND_PRI = 2'b11
   } iebk_kind_type;

endpackage

/* iebk_top.sv */
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "iebk_consts.svh"

module iebk_top (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire iebk_pkg::iebk_apb_req_type apb_in,
   input wire iebk_pkg::iebk_bank_type src_req_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output iebk_pkg::iebk_bank_type irq_req_out,
   output logic [2:0] irq_level_out
);
   import iebk_pkg::*;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------

   // replace one 16-bit bank word of a flat vector
   function automatic logic [47:0] put_word(input logic [47:0] v, input logic [1:0] b,
                                            input logic [15:0] d);
      logic [47:0] r;
      r = v;
      case (b)
         2'b00: r[15:0] = d;
         2'b01: r[31:16] = d;
         default: r[47:32] = d;
      endcase
      return r;
   endfunction

   // pick one 16-bit bank word of a flat vector
   function automatic logic [15:0] get_word(input logic [47:0] v, input logic [1:0] b);
      logic [15:0] r;
      case (b)
         2'b00: r = v[15:0];
         2'b01: r = v[31:16];
         default: r = v[47:32];
      endcase
      return r;
   endfunction

   // flat source position of field f in priority word idx
   function automatic int pri_pos(input logic [3:0] idx, input int f);
      return int'(idx) * `IEBK_PRI_PER_WORD + f;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   localparam logic [47:0] IMPL = {`IEBK_MASK3, `IEBK_MASK2, `IEBK_MASK1};

   // registered state and next values
   logic [47:0] en_q, en_d;
   logic [47:0] flg_q, flg_d;
   logic [2:0] pri_q [0:47];
   logic [2:0] pri_d [0:47];
   logic [47:0] pend_q, pend_d;
   logic [2:0] lvl_q, lvl_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;

   // decode and handshake helpers
   iebk_kind_type kind;
   logic [1:0] bank;
   logic [3:0] pri_idx;
   logic [7:0] pri_ofs;
   logic [47:0] src_flat;
   logic wr_en;
   logic setup;

   // source requests as one flat vector
   assign src_flat = {src_req_in.w3, src_req_in.w2, src_req_in.w1};

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------

   // group, bank word and priority word for the held address
   always_comb begin
      kind = IEBK_KIND_NONE;
      bank = 2'b00;
      pri_ofs = apb_in.paddr - `IEBK_OFS_PRI_FIRST;
      pri_idx = pri_ofs[5:2];
      if (apb_in.paddr == `IEBK_OFS_EN1) begin
         kind = IEBK_KIND_EN;
         bank = 2'b00;
      end else if (apb_in.paddr == `IEBK_OFS_EN2) begin
         kind = IEBK_KIND_EN;
         bank = 2'b01;
      end else if (apb_in.paddr == `IEBK_OFS_EN3) begin
         kind = IEBK_KIND_EN;
         bank = 2'b10;
      end else if (apb_in.paddr == `IEBK_OFS_FLG1) begin
         kind = IEBK_KIND_FLG;
         bank = 2'b00;
      end else if (apb_in.paddr == `IEBK_OFS_FLG2) begin
         kind = IEBK_KIND_FLG;
         bank = 2'b01;
      end else if (apb_in.paddr == `IEBK_OFS_FLG3) begin
         kind = IEBK_KIND_FLG;
         bank = 2'b10;
      end else if (apb_in.paddr >= `IEBK_OFS_PRI_FIRST && apb_in.paddr <= `IEBK_OFS_PRI_LAST
                   && apb_in.paddr[1:0] == 2'b00) begin
         kind = IEBK_KIND_PRI;
      end
   end

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   assign setup = apb_in.psel & ~apb_in.penable;
   assign wr_en = apb_in.psel & apb_in.penable & apb_in.pwrite & pready_q;

   // read data and error caught in setup, presented in the access cycle
   always_comb begin
      int pos;
      pos = 0;
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      pready_d = setup;
      if (setup) begin
         prdata_d = 32'h0000_0000;
         case (kind)
            IEBK_KIND_EN: prdata_d[15:0] = get_word(en_q & IMPL, bank);
            IEBK_KIND_FLG: prdata_d[15:0] = get_word(flg_q & IMPL, bank);
            IEBK_KIND_PRI: begin
               for (int f = 0; f < `IEBK_PRI_PER_WORD; f++) begin
                  pos = pri_pos(pri_idx, f);
                  if (IMPL[pos]) begin
                     prdata_d[f*`IEBK_PRI_FIELD_W +: 3] = pri_q[pos];
                  end
               end
            end
            default: pslverr_d = 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // enable registers
   // ----------------------------------------------------------------

   // software write, masked to implemented positions
   always_comb begin
      logic [15:0] wdata;
      wdata = apb_in.pwdata[15:0] & get_word(IMPL, bank);
      en_d = en_q;
      if (wr_en && kind == IEBK_KIND_EN) begin
         en_d = put_word(en_q, bank, wdata);
      end
   end

   // ----------------------------------------------------------------
   // flag registers
   // ----------------------------------------------------------------

   // software write first, then source sets, so a set beats a clear
   always_comb begin
      logic [15:0] wdata;
      wdata = apb_in.pwdata[15:0] & get_word(IMPL, bank);
      flg_d = flg_q;
      if (wr_en && kind == IEBK_KIND_FLG) begin
         flg_d = put_word(flg_q, bank, wdata);
      end
      flg_d = (flg_d | src_flat) & IMPL;
   end

   // ----------------------------------------------------------------
   // priority registers
   // ----------------------------------------------------------------

   // four fields per word, absent positions never written
   always_comb begin
      int pos;
      pos = 0;
      for (int p = 0; p < `IEBK_NUM_POS; p++) begin
         pri_d[p] = pri_q[p];
      end
      if (wr_en && kind == IEBK_KIND_PRI) begin
         for (int f = 0; f < `IEBK_PRI_PER_WORD; f++) begin
            pos = pri_pos(pri_idx, f);
            if (IMPL[pos]) begin
               pri_d[pos] = apb_in.pwdata[f*`IEBK_PRI_FIELD_W +: 3];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // request forwarding
   // ----------------------------------------------------------------

   // forward flag and enable with nonzero priority, track top level
   always_comb begin
      lvl_d = `IEBK_PRI_OFF;
      for (int p = 0; p < `IEBK_NUM_POS; p++) begin
         pend_d[p] = flg_q[p] & en_q[p] & IMPL[p] & (pri_q[p] != `IEBK_PRI_OFF);
         if (pend_d[p] && pri_q[p] > lvl_d) begin
            lvl_d = pri_q[p];
         end
      end
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------

   // apb answer registers
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // enable registers, all clear at reset
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         en_q <= {`IEBK_EN_RST, `IEBK_EN_RST, `IEBK_EN_RST};
      end else begin
         en_q <= en_d;
      end
   end

   // flag registers
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         flg_q <= {`IEBK_FLG_RST, `IEBK_FLG_RST, `IEBK_FLG_RST};
      end else begin
         flg_q <= flg_d;
      end
   end

   // priority registers
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int p = 0; p < `IEBK_NUM_POS; p++) begin
            pri_q[p] <= `IEBK_PRI_RST;
         end
      end else begin
         for (int p = 0; p < `IEBK_NUM_POS; p++) begin
            pri_q[p] <= pri_d[p];
         end
      end
   end

   // forwarded requests and top level
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pend_q <= 48'h0000_0000_0000;
         lvl_q <= `IEBK_PRI_OFF;
      end else begin
         pend_q <= pend_d;
         lvl_q <= lvl_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // every output straight from its register
   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign irq_req_out = {pend_q[47:32], pend_q[31:16], pend_q[15:0]};
   assign irq_level_out = lvl_q;

endmodule

/* iebk_src_model.sv */
`timescale 1ns/1ps
// ----------------
// peripheral source model
// ----------------
module iebk_src_model (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire iebk_pkg::iebk_bank_type fire_in,
   output iebk_pkg::iebk_bank_type src_req_out
);
   import iebk_pkg::*;
   iebk_bank_type src_q;
   iebk_bank_type src_d;
   // external irq inputs are taken as already routed to a pin
   always_comb begin
      src_d = fire_in;
   end
   // one-cycle request per commanded source
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         src_q <= '0;
      end else begin
         src_q <= src_d;
      end
   end
   assign src_req_out = src_q;
endmodule

/* iebk_top_chk.sv */
`timescale 1ns/1ps
`include "iebk_consts.svh"
module iebk_chk (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire iebk_pkg::iebk_apb_req_type apb_in,
   input wire iebk_pkg::iebk_bank_type src_req_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire iebk_pkg::iebk_bank_type irq_req_out,
   input wire logic [2:0] irq_level_out
);
   import iebk_pkg::*;
   logic setup;
   logic mapped;
   logic [47:0] impl;
   // setup phase, address decode and implemented positions
   assign setup = apb_in.psel && !apb_in.penable;
   assign mapped = apb_in.paddr[1:0] == 2'h0 && (apb_in.paddr <= `IEBK_OFS_EN3
      || (apb_in.paddr >= `IEBK_OFS_FLG1 && apb_in.paddr <= `IEBK_OFS_FLG3)
      || apb_in.paddr >= `IEBK_OFS_PRI_FIRST) && apb_in.paddr <= `IEBK_OFS_PRI_LAST;
   assign impl = {`IEBK_MASK3, `IEBK_MASK2, `IEBK_MASK1};
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   chk_ready_after_setup: assert property (setup |=> pready_out)
      else $error("no pready after setup");
   chk_ready_in_access: assert property (pready_out |-> apb_in.psel && apb_in.penable)
      else $error("pready outside access");
   chk_ready_one_cycle: assert property (pready_out |=> !pready_out)
      else $error("pready too long");
   chk_err_unmapped: assert property (setup && !mapped |=> pslverr_out && prdata_out == '0)
      else $error("unmapped access not refused");
   chk_ok_mapped: assert property (setup && mapped |=> !pslverr_out)
      else $error("mapped access refused");
   chk_upper_zero: assert property (pready_out |-> prdata_out[31:16] == 16'h0000)
      else $error("upper read bits set");
   chk_unimpl_quiet: assert property ((irq_req_out & ~impl) == '0)
      else $error("request on absent position");
   chk_level_idle: assert property (irq_req_out == '0 |-> irq_level_out == 3'h0)
      else $error("level without request");
   chk_level_busy: assert property (irq_req_out != '0 |-> irq_level_out != 3'h0)
      else $error("request with level zero");
   chk_reset_quiet: assert property ($rose(resetn_in) |-> irq_req_out == '0 && !pready_out)
      else $error("outputs active after reset");
   cover property (setup && !mapped ##1 pslverr_out);
   cover property (irq_level_out == 3'h7);
   cover property (setup && apb_in.pwrite ##1 pready_out);
endmodule
bind iebk_top iebk_chk i_iebk_chk (.ref_clk_in, .resetn_in, .apb_in, .src_req_in,
   .prdata_out, .pready_out, .pslverr_out, .irq_req_out, .irq_level_out);

/* iebk_tb_top.sv */
`timescale 1ns/1ps
`include "iebk_consts.svh"
module iebk_tb_top;
   import iebk_pkg::*;
   logic clk, rstn, rdy, err, e;
   iebk_apb_req_type apb;
   iebk_bank_type fire, src, irq;
   logic [31:0] rd, v, d;
   logic [2:0] lvl;
   int num_errors, checks, seed;
   iebk_top i_iebk_top (.ref_clk_in(clk), .resetn_in(rstn), .apb_in(apb), .src_req_in(src),
      .prdata_out(rd), .pready_out(rdy), .pslverr_out(err), .irq_req_out(irq),
      .irq_level_out(lvl));
   iebk_src_model i_iebk_src_model (.ref_clk_in(clk), .resetn_in(rstn), .fire_in(fire),
      .src_req_out(src));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // expected writable bits per enable word
   function logic [15:0] msk(int i);
      return i == 0 ? `IEBK_MASK1 : i == 1 ? `IEBK_MASK2 : `IEBK_MASK3;
   endfunction
   task chk(input string n, input logic [63:0] s, input logic [63:0] x);
      checks++;
      if (s !== x) begin
         num_errors++;
         $display("MISMATCH %s exp %h seen %h", n, x, s);
      end
   endtask
   task end_sim;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one apb transfer, result in v and e
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] dw);
      int n;
      n = 0;
      @(posedge clk);
      apb <= '{1'b1, 1'b0, w, a, dw};
      @(posedge clk);
      apb.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 16);
      if (n >= 16) num_errors++;
      v = rd;
      e = err;
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
   endtask
   task pulse(input iebk_bank_type f);
      @(posedge clk);
      fire <= f;
      @(posedge clk);
      fire <= '0;
      repeat (4) @(posedge clk);
   endtask
   initial begin
      seed = 94577;
      rstn = 0;
      apb = '0;
      fire = '0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         xfer(0, 8'(4 * i), 0);
         chk("en_rst", v, 0);
      end
      xfer(0, 8'h24, 0);
      chk("pri_rst", v, 32'h0000_4404);
      for (int k = 0; k < 12; k++) begin
         d = k < 3 ? 32'hFFFF_FFFF : $random(seed);
         xfer(1, 8'(4 * (k % 3)), d);
         xfer(0, 8'(4 * (k % 3)), 0);
         chk("en_rw", v, d[15:0] & msk(k % 3));
      end
      xfer(1, 8'h0C, 32'hFFFF_FFFF);
      chk("err", e, 1);
      xfer(0, 8'h01, 0);
      chk("err_data", {e, v}, 33'h1_0000_0000);
      xfer(1, 8'h00, 1);
      xfer(1, 8'h04, 0);
      xfer(1, 8'h08, 0);
      pulse(48'h1);
      chk("irq", {lvl, irq}, {`IEBK_PRI_RST, 48'h1});
      xfer(1, 8'h20, 7);
      repeat (3) @(posedge clk);
      chk("lvl7", lvl, 7);
      xfer(0, 8'h20, 0);
      chk("pri_rd", v, 7);
      xfer(1, 8'h20, 0);
      repeat (3) @(posedge clk);
      chk("prio_off", {lvl, irq}, 0);
      xfer(1, 8'h20, 7);
      xfer(1, 8'h00, 0);
      repeat (3) @(posedge clk);
      chk("en_off", irq, 0);
      xfer(0, 8'h10, 0);
      chk("flag_kept", v, 1);
      xfer(1, 8'h10, 0);
      xfer(1, 8'h00, 32'h0000_FFFF);
      xfer(1, 8'h08, 32'h0000_FFFF);
      pulse(48'h4000_0000_0120);
      chk("absent", irq, 48'h4000_0000_0000);
      xfer(0, 8'h10, 0);
      chk("flag_absent", v, 0);
      xfer(1, 8'h20, 32'h0000_0060);
      pulse(48'h2);
      chk("lvl_max", {lvl, irq}, {3'h6, 48'h4000_0000_0002});
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      chk("rst_irq", {lvl, irq}, 0);
      xfer(0, 8'h08, 0);
      chk("rst_en", v, 0);
      xfer(0, 8'h18, 0);
      chk("rst_flag", v, 0);
      end_sim;
   end
   initial begin
      #100_000;
      num_errors++;
      end_sim;
   end
endmodule
